// ### design/dcc_clock_ctrl.v
// decoder clock control: clock enables, sleep, register slave and interrupt line
//
// Overview of operation
// - master clock is eight times the crystal, feeding most decoder clocks
// - crystal select bit halves a 16.934 MHz crystal before multiplication
// - system clock is master halved, then divided by system_divider field
// - sleep bit in system_clock_config stops most decoder clocks
// - bit clock domain drives serial audio logic; only the internal bit clock goes out as serial clock
// - bit clock config selects division ratio and enables gating
// - spdif clock only in slave mode, divided by spdif_clock_config
// - adc sample clock runs at the master clock rate
// - bit clock reception selects the external incoming bit clock
// - debug monitor clock rate set by aux_clock_config
// - external dac clock rate set by aux_clock_config
// - each 8-bit register sits in the low byte of a 32-bit word
// - decoder registers at 000h-24Ch, other functions at 2A0h-374h
// - latched status bits set by hardware, cleared by reading
// - live status bits follow their sources, cleared by hardware or clear access
// - interrupt line low when any enabled status bit is set
// - disabled status bits still set and clear but do not interrupt
`timescale 1ns/100ps
`include "dcc_consts.vh"

module dcc_clock_ctrl #(
    parameter NSTAT = 8
)(
    // clock and reset (sys_clk stands for the multiplied master clock)
    input  wire                    sys_clk,
    input  wire                    rst_n,
    input  wire                    clk_en,
    // register port
    input  wire [`DCC_ADDR_W-1:0]  reg_addr,
    input  wire [31:0]             reg_wdata,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    output reg  [31:0]             reg_rdata,
    // status event sources from decoder blocks
    input  wire [NSTAT-1:0]        latched_events,
    input  wire [NSTAT-1:0]        live_sources,
    // external bit clock pin
    input  wire                    bclk_in_pin,
    // clock enables and divided clocks for decoder domains
    output reg                     sysclk_en,
    output reg                     adc_sample_clock_en,
    output reg                     bitclk_en,
    output reg                     spdif_clk_en,
    output reg                     debug_monitor_clock,
    output reg                     ext_dac_clock,
    output reg                     serial_clock_out,
    // analog and audio control
    output reg                     crystal_halve_select,
    output reg                     spdif_enable,
    output reg                     sleep_out,
    // immigrant space access for other chip functions
    output reg                     imm_wr,
    output reg  [`DCC_ADDR_W-1:0]  imm_addr,
    output reg  [7:0]              imm_wdata,
    input  wire [7:0]              imm_rdata,
    // interrupt line
    output reg                     irq_n
);

    // configuration registers
    reg [7:0] analog_pll_control_r;
    reg [7:0] system_clock_config_r;
    reg [7:0] bit_clock_config_a_r;
    reg [7:0] spdif_clock_config_r;
    reg [7:0] aux_clock_config_r;
    reg [7:0] serial_audio_config_r;
    reg [NSTAT-1:0] latched_irq_status_r;
    reg [NSTAT-1:0] live_irq_status_r;
    reg [NSTAT-1:0] latched_irq_enable_r;
    reg [NSTAT-1:0] live_irq_enable_r;
    reg [NSTAT-1:0] live_prev_r;
    // dividers
    reg [7:0] half_cnt_r;
    reg [7:0] sys_cnt_r;
    reg [7:0] bit_cnt_r;
    reg [7:0] spdif_cnt_r;
    reg [3:0] dbg_cnt_r;
    reg [3:0] dac_cnt_r;
    reg       bclk_meta_r;
    reg       bclk_sync_r;
    reg       bclk_prev_r;
    reg       bit_int_r;
    reg       imm_rd_r;

    wire [4:0] sys_div   = system_clock_config_r[4:0];
    wire       sleep     = system_clock_config_r[`DCC_SYS_SLEEP_BIT];
    wire [6:0] bit_div   = bit_clock_config_a_r[6:0];
    wire       bit_gate  = bit_clock_config_a_r[`DCC_BIT_GATE_BIT];
    wire       slave_md  = serial_audio_config_r[`DCC_SER_SLAVE_BIT];
    wire       bclk_rx   = serial_audio_config_r[`DCC_SER_BCKIN_BIT];
    wire       spdif_req = serial_audio_config_r[`DCC_SER_SPDIF_BIT];
    wire       half_tick = (half_cnt_r == 8'h00);
    // at-or-above compare: a divider cut below the running count ends the period at once, no wrap
    wire       sys_tick  = half_tick && (sys_cnt_r >= {3'h0, sys_div});
    wire       bit_tick  = (bit_cnt_r >= {1'h0, bit_div});
    wire       spdif_tick = (spdif_cnt_r >= spdif_clock_config_r);
    wire       bclk_rise = bclk_sync_r & ~bclk_prev_r;
    wire [NSTAT-1:0] live_rise = live_sources & ~live_prev_r;
    wire       is_imm    = (reg_addr >= `DCC_IMM_LO) && (reg_addr <= `DCC_IMM_HI);
    wire       hit_lstat = reg_rd && (reg_addr == `DCC_OFF_LSTAT);
    wire       hit_vclr  = reg_wr && (reg_addr == `DCC_OFF_VCLR);
    wire       irq_any   = |(latched_irq_status_r & latched_irq_enable_r) |
                           |(live_irq_status_r & live_irq_enable_r);

    // register writes; configuration steers the dividers below
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            analog_pll_control_r  <= `DCC_RST_PLLCTL;
            system_clock_config_r <= `DCC_RST_SYSCLK;
            bit_clock_config_a_r  <= `DCC_RST_BITCLK;
            spdif_clock_config_r  <= `DCC_RST_SPDIFCLK;
            aux_clock_config_r    <= `DCC_RST_AUXCLK;
            serial_audio_config_r <= `DCC_RST_SERCFG;
            latched_irq_enable_r  <= {NSTAT{1'b0}};
            live_irq_enable_r     <= {NSTAT{1'b0}};
        end
        else if (clk_en && reg_wr)
        begin
            case (reg_addr)
                `DCC_OFF_PLLCTL:   analog_pll_control_r  <= reg_wdata[7:0];
                `DCC_OFF_SYSCLK:   system_clock_config_r <= reg_wdata[7:0];
                `DCC_OFF_BITCLK:   bit_clock_config_a_r  <= reg_wdata[7:0];
                `DCC_OFF_SPDIFCLK: spdif_clock_config_r  <= reg_wdata[7:0];
                `DCC_OFF_AUXCLK:   aux_clock_config_r    <= reg_wdata[7:0];
                `DCC_OFF_SERCFG:   serial_audio_config_r <= reg_wdata[7:0];
                `DCC_OFF_LEN:      latched_irq_enable_r  <= reg_wdata[NSTAT-1:0];
                `DCC_OFF_VEN:      live_irq_enable_r     <= reg_wdata[NSTAT-1:0];
                default:           ;
            endcase
        end
    end

    // status bits; set wins over a read clear in the same cycle
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            latched_irq_status_r <= {NSTAT{1'b0}};
            live_irq_status_r    <= {NSTAT{1'b0}};
            live_prev_r          <= {NSTAT{1'b0}};
        end
        else if (clk_en)
        begin
            // enables do not gate the status, so disabled bits stay pollable
            latched_irq_status_r <= (hit_lstat ? {NSTAT{1'b0}} : latched_irq_status_r)
                                    | latched_events;
            // live bits follow the source; a clear holds a bit low until its source rises again
            live_irq_status_r    <= ((live_irq_status_r & ~(hit_vclr ? reg_wdata[NSTAT-1:0] : {NSTAT{1'b0}}))
                                    | live_rise) & live_sources;
            live_prev_r          <= live_sources;
        end
    end

    // read data, one cycle after the strobe, upper 24 bits zero
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 32'h0000_0000;
            imm_rd_r  <= 1'b0;
        end
        else if (clk_en)
        begin
            imm_rd_r  <= reg_rd && is_imm;
            reg_rdata <= 32'h0000_0000;
            if (reg_rd)
            begin
                case (reg_addr)
                    `DCC_OFF_PLLCTL:   reg_rdata[7:0] <= analog_pll_control_r;
                    `DCC_OFF_SYSCLK:   reg_rdata[7:0] <= system_clock_config_r;
                    `DCC_OFF_BITCLK:   reg_rdata[7:0] <= bit_clock_config_a_r;
                    `DCC_OFF_SPDIFCLK: reg_rdata[7:0] <= spdif_clock_config_r;
                    `DCC_OFF_AUXCLK:   reg_rdata[7:0] <= aux_clock_config_r;
                    `DCC_OFF_SERCFG:   reg_rdata[7:0] <= serial_audio_config_r;
                    `DCC_OFF_LSTAT:    reg_rdata[NSTAT-1:0] <= latched_irq_status_r;
                    `DCC_OFF_VSTAT:    reg_rdata[NSTAT-1:0] <= live_irq_status_r;
                    `DCC_OFF_LEN:      reg_rdata[NSTAT-1:0] <= latched_irq_enable_r;
                    `DCC_OFF_VEN:      reg_rdata[NSTAT-1:0] <= live_irq_enable_r;
                    default:           reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // immigrant space writes are passed out one cycle late; reads there return zero, imm_rdata is not used
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            imm_wr    <= 1'b0;
            imm_addr  <= {`DCC_ADDR_W{1'b0}};
            imm_wdata <= 8'h00;
        end
        else if (clk_en)
        begin
            imm_wr    <= reg_wr && is_imm;
            imm_addr  <= reg_addr;
            imm_wdata <= reg_wdata[7:0];
        end
    end

    // system clock: master halved (50 % via every other edge), then divided
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            half_cnt_r <= 8'h00;
            sys_cnt_r  <= 8'h00;
            sysclk_en  <= 1'b0;
        end
        else if (clk_en)
        begin
            half_cnt_r <= {7'h00, ~half_cnt_r[0]};
            if (half_tick)
                sys_cnt_r <= sys_tick ? 8'h00 : sys_cnt_r + 8'h01;
            sysclk_en <= sys_tick && !sleep;
        end
    end

    // adc sample enable runs every master cycle, stopped only by sleep
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            adc_sample_clock_en  <= 1'b0;
            crystal_halve_select <= 1'b0;
            sleep_out            <= 1'b0;
            spdif_enable         <= 1'b0;
        end
        else if (clk_en)
        begin
            adc_sample_clock_en  <= !sleep;
            crystal_halve_select <= analog_pll_control_r[`DCC_PLL_CRYSTAL_HALVE_SELECT_BIT];
            sleep_out            <= sleep;
            spdif_enable         <= spdif_req && slave_md;
        end
    end

    // incoming bit clock pin, two-stage sync before edge detection
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bclk_meta_r <= 1'b0;
            bclk_sync_r <= 1'b0;
            bclk_prev_r <= 1'b0;
        end
        else if (clk_en)
        begin
            bclk_meta_r <= bclk_in_pin;
            bclk_sync_r <= bclk_meta_r;
            bclk_prev_r <= bclk_sync_r;
        end
    end

    // bit clock: internal divider or external pin; gating holds it when disabled
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bit_cnt_r        <= 8'h00;
            bit_int_r        <= 1'b0;
            bitclk_en        <= 1'b0;
            serial_clock_out <= 1'b0;
        end
        else if (clk_en)
        begin
            bit_cnt_r <= bit_tick ? 8'h00 : bit_cnt_r + 8'h01;
            if (bit_tick)
                bit_int_r <= ~bit_int_r;
            if (bclk_rx)
            begin
                bitclk_en        <= bclk_rise && !sleep;
                serial_clock_out <= 1'b0;
            end
            else
            begin
                // gated mode stops the clock in sleep; ungated keeps it free running
                bitclk_en        <= bit_tick && bit_int_r && !(bit_gate && sleep);
                serial_clock_out <= bit_gate && sleep ? 1'b0 : bit_int_r;
            end
        end
    end

    // spdif clock divider, enabled only in slave mode
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            spdif_cnt_r  <= 8'h00;
            spdif_clk_en <= 1'b0;
        end
        else if (clk_en)
        begin
            spdif_cnt_r  <= spdif_tick ? 8'h00 : spdif_cnt_r + 8'h01;
            spdif_clk_en <= spdif_tick && slave_md && spdif_req && !sleep;
        end
    end

    // aux clocks: low nibble sets debug monitor rate, high nibble dac rate
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dbg_cnt_r           <= 4'h0;
            dac_cnt_r           <= 4'h0;
            debug_monitor_clock <= 1'b0;
            ext_dac_clock       <= 1'b0;
        end
        else if (clk_en)
        begin
            if (dbg_cnt_r >= aux_clock_config_r[3:0])
            begin
                dbg_cnt_r           <= 4'h0;
                debug_monitor_clock <= ~debug_monitor_clock;
            end
            else
                dbg_cnt_r <= dbg_cnt_r + 4'h1;
            if (dac_cnt_r >= aux_clock_config_r[7:4])
            begin
                dac_cnt_r     <= 4'h0;
                ext_dac_clock <= ~ext_dac_clock;
            end
            else
                dac_cnt_r <= dac_cnt_r + 4'h1;
        end
    end

    // interrupt line, active low, registered
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_n <= 1'b1;
        else if (clk_en)
            irq_n <= ~irq_any;
    end

endmodule

// ### design/dcc_consts.vh
// register offsets, field positions, reset values and clock constants for the decoder clock block
`ifndef DCC_CONSTS_VH
`define DCC_CONSTS_VH
// byte offsets of registers (word per register, low byte used)
`define DCC_ADDR_W          10
`define DCC_OFF_PLLCTL      10'h000
`define DCC_OFF_SYSCLK      10'h004
`define DCC_OFF_BITCLK      10'h008
`define DCC_OFF_SPDIFCLK    10'h00C
`define DCC_OFF_AUXCLK      10'h010
`define DCC_OFF_SERCFG      10'h014
`define DCC_OFF_LSTAT       10'h018
`define DCC_OFF_VSTAT       10'h01C
`define DCC_OFF_LEN         10'h020
`define DCC_OFF_VEN         10'h024
`define DCC_OFF_VCLR        10'h028
// decoder and immigrant space limits
`define DCC_DEC_TOP         10'h24C
`define DCC_IMM_LO          10'h2A0
`define DCC_IMM_HI          10'h374
// field positions
`define DCC_PLL_CRYSTAL_HALVE_SELECT_BIT   0
`define DCC_SYS_SLEEP_BIT   7
`define DCC_BIT_GATE_BIT    7
`define DCC_SER_SLAVE_BIT   0
`define DCC_SER_BCKIN_BIT   1
`define DCC_SER_SPDIF_BIT   2
// reset values
`define DCC_RST_PLLCTL      8'h00
`define DCC_RST_SYSCLK      8'h00
`define DCC_RST_BITCLK      8'h17
`define DCC_RST_SPDIFCLK    8'h17
`define DCC_RST_AUXCLK      8'h00
`define DCC_RST_SERCFG      8'h00
`define DCC_RST_EN          8'h00
// clock figures in kHz
`define DCC_XCLK_KHZ        67738
`define DCC_XTAL_KHZ        8467
`define DCC_XMUL            8
`endif

// ### testbench/dcc_clock_ctrl_checker.sv
// port-level assertions for the decoder clock control block
`timescale 1ns/100ps
`include "dcc_consts.vh"
module dcc_clock_ctrl_checker #(
    parameter NSTAT = 8
)(
    input wire logic                   sys_clk,
    input wire logic                   rst_n,
    input wire logic [`DCC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0]            reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [31:0]            reg_rdata,
    input wire logic [NSTAT-1:0]       latched_events,
    input wire logic [NSTAT-1:0]       live_sources,
    input wire logic                   sysclk_en,
    input wire logic                   spdif_enable,
    input wire logic                   sleep_out,
    input wire logic                   imm_wr,
    input wire logic [`DCC_ADDR_W-1:0] imm_addr,
    input wire logic [7:0]             imm_wdata,
    input wire logic                   irq_n
);
    reg [7:0] len_r;
    reg [7:0] ven_r;
    reg [7:0] sys_r;
    reg [2:0] ser_r;
    reg [1:0] age_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // shadow of written config; age lets registered outputs settle
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            len_r <= 8'h00;
            ven_r <= 8'h00;
            sys_r <= 8'h00;
            ser_r <= 3'h0;
            age_r <= 2'h0;
        end
        else if (reg_wr)
        begin
            age_r <= 2'h0;
            if (reg_addr == `DCC_OFF_LEN) len_r <= reg_wdata[7:0];
            if (reg_addr == `DCC_OFF_VEN) ven_r <= reg_wdata[7:0];
            if (reg_addr == `DCC_OFF_SYSCLK) sys_r <= reg_wdata[7:0];
            if (reg_addr == `DCC_OFF_SERCFG) ser_r <= reg_wdata[2:0];
        end
        else if (age_r != 2'h3)
            age_r <= age_r + 2'h1;
    end

    upper_zero_a: assert property (reg_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    imm_fwd_a: assert property (reg_wr && reg_addr >= `DCC_IMM_LO && reg_addr <= `DCC_IMM_HI
        |=> imm_wr && imm_addr == $past(reg_addr) && imm_wdata == $past(reg_wdata[7:0]))
        else $error("far write not forwarded");
    imm_block_a: assert property (reg_wr && reg_addr <= `DCC_DEC_TOP |=> !imm_wr)
        else $error("decoder write leaked");
    sleep_level_a: assert property (age_r == 2'h3 |-> sleep_out == sys_r[7])
        else $error("sleep level wrong");
    sleep_stop_a: assert property (age_r == 2'h3 && sys_r[7] |-> !sysclk_en)
        else $error("system enable in sleep");
    spdif_slave_a: assert property (age_r == 2'h3 |-> spdif_enable == (ser_r[0] && ser_r[2]))
        else $error("spdif enable wrong");
    sysclk_half_a: assert property (sysclk_en |=> !sysclk_en)
        else $error("system enable too dense");
    latch_irq_a: assert property ((latched_events & len_r[NSTAT-1:0]) != 0 |-> ##[1:3] !irq_n)
        else $error("latched irq missing");
    live_irq_a: assert property ((live_sources & ~$past(live_sources) & ven_r[NSTAT-1:0]) != 0
        |-> ##[1:3] !irq_n)
        else $error("live irq missing");
    mask_quiet_a: assert property (age_r == 2'h3 && len_r == 8'h00 && ven_r == 8'h00 |-> irq_n)
        else $error("masked irq asserted");
    irq_release_a: assert property ((len_r == 8'h00 && (live_sources & ven_r[NSTAT-1:0]) == 0) [*3]
        |-> irq_n)
        else $error("irq not released");
endmodule

// ### testbench/dcc_clock_ctrl_tb.sv
// self-checking bench for the decoder clock control block
`timescale 1ns/100ps
`include "dcc_consts.vh"
module dcc_clock_ctrl_tb;
    logic                   sys_clk;
    logic                   rst_n;
    logic [`DCC_ADDR_W-1:0] reg_addr;
    logic [31:0]            reg_wdata;
    logic                   reg_wr;
    logic                   reg_rd;
    logic [31:0]            reg_rdata;
    logic [7:0]             latched_events;
    logic [7:0]             live_sources;
    logic [`DCC_ADDR_W-1:0] imm_addr;
    logic [7:0]             imm_wdata;
    logic                   sysclk_en, serial_clock_out, crystal_halve_select;
    logic                   spdif_enable, sleep_out, imm_wr, irq_n;
    logic                   adc_sample_clock_en, bitclk_en, spdif_clk_en, debug_monitor_clock, ext_dac_clock;
    logic [2:0]             bclk_cnt;
    int                     err_count = 0;
    int                     compares = 0;
    int                     cycles = 0;

    dcc_host_model u_host (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

    dcc_clock_ctrl u_dcc_clock_ctrl (.sys_clk, .rst_n, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .latched_events, .live_sources, .bclk_in_pin(bclk_cnt[2]), .sysclk_en,
        .adc_sample_clock_en, .bitclk_en, .spdif_clk_en, .debug_monitor_clock, .ext_dac_clock,
        .serial_clock_out, .crystal_halve_select, .spdif_enable, .sleep_out, .imm_wr, .imm_addr,
        .imm_wdata, .imm_rdata(8'h00), .irq_n);

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    // free-running incoming bit clock, one rise every eight cycles
    always @(posedge sys_clk) bclk_cnt <= bclk_cnt + 3'h1;

    // hang guard, well above the roughly 1200 cycles the run needs
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] d;
        u_host.rd(a, d);
        chk(d, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // cycles between rises; first interval skipped since it may straddle a divider change
    // s picks the output: 0 sysclk_en, 1 serial clock, 2 debug, 3 dac, 4 spdif, else bitclk_en
    task automatic period(input int s, output int n);
        int k;
        bit p;
        bit c;
        n = 0;
        k = 0;
        p = 1'b1;
        repeat (400)
        begin
            @(posedge sys_clk);
            #1;
            case (s)
                0: c = sysclk_en;
                1: c = serial_clock_out;
                2: c = debug_monitor_clock;
                3: c = ext_dac_clock;
                4: c = spdif_clk_en;
                default: c = bitclk_en;
            endcase
            if (k == 2) n++;
            if (c && !p) k++;
            p = c;
            if (k == 3) break;
        end
    endtask

    task automatic t_reset_map;
        rchk(`DCC_OFF_PLLCTL, {24'h0, `DCC_RST_PLLCTL});
        rchk(`DCC_OFF_BITCLK, {24'h0, `DCC_RST_BITCLK});
        rchk(`DCC_OFF_SPDIFCLK, {24'h0, `DCC_RST_SPDIFCLK});
        rchk(10'h100, 32'h0);
        u_host.wr(`DCC_OFF_AUXCLK, 8'h3C);
        rchk(`DCC_OFF_AUXCLK, 32'h3C);
        u_host.wr(`DCC_IMM_LO, 8'h5A);
        u_host.wr(`DCC_IMM_HI, 8'hC3);
        rchk(`DCC_IMM_LO, 32'h0);
    endtask

    task automatic t_clocks;
        int n;
        chk(adc_sample_clock_en, 32'h1);
        u_host.wr(`DCC_OFF_SYSCLK, 8'h03);
        period(0, n);
        chk(n, 32'd8);
        u_host.wr(`DCC_OFF_SYSCLK, 8'h00);
        period(0, n);
        chk(n, 32'd2);
        u_host.wr(`DCC_OFF_BITCLK, 8'h02);
        period(1, n);
        chk(n, 32'd6);
        period(5, n);
        chk(n, 32'd6);
        period(2, n);
        chk(n, 32'd26);
        period(3, n);
        chk(n, 32'd8);
        u_host.wr(`DCC_OFF_PLLCTL, 8'h01);
        settle(3);
        chk(crystal_halve_select, 32'h1);
        u_host.wr(`DCC_OFF_BITCLK, 8'h82);
        u_host.wr(`DCC_OFF_SYSCLK, 8'h80);
        settle(40);
        chk(sleep_out, 32'h1);
        chk(adc_sample_clock_en, 32'h0);
        period(1, n);
        chk(n, 32'd0);
        u_host.wr(`DCC_OFF_SYSCLK, 8'h00);
    endtask

    task automatic t_spdif;
        int n;
        u_host.wr(`DCC_OFF_SERCFG, 8'h05);
        settle(3);
        chk(spdif_enable, 32'h1);
        period(4, n);
        chk(n, `DCC_RST_SPDIFCLK + 32'd1);
        u_host.wr(`DCC_OFF_SERCFG, 8'h04);
        settle(3);
        chk(spdif_enable, 32'h0);
        period(4, n);
        chk(n, 32'd0);
        u_host.wr(`DCC_OFF_SERCFG, 8'h02);
        period(5, n);
        chk(n, 32'd8);
        chk(serial_clock_out, 32'h0);
        u_host.wr(`DCC_OFF_SERCFG, 8'h00);
    endtask

    task automatic t_irq;
        u_host.wr(`DCC_OFF_VEN, 8'h08);
        live_sources <= 8'h08;
        settle(3);
        chk(irq_n, 32'h0);
        rchk(`DCC_OFF_VSTAT, 32'h08);
        u_host.wr(`DCC_OFF_VCLR, 8'h08);
        settle(2);
        rchk(`DCC_OFF_VSTAT, 32'h00);
        chk(irq_n, 32'h1);
        @(posedge sys_clk);
        live_sources <= 8'h00;
        @(posedge sys_clk);
        live_sources <= 8'h08;
        settle(3);
        chk(irq_n, 32'h0);
        @(posedge sys_clk);
        live_sources <= 8'h00;
        settle(3);
        chk(irq_n, 32'h1);
        rchk(`DCC_OFF_VSTAT, 32'h00);
        u_host.wr(`DCC_OFF_LEN, 8'h01);
        latched_events <= 8'h03;
        @(posedge sys_clk);
        latched_events <= 8'h00;
        settle(3);
        chk(irq_n, 32'h0);
        rchk(`DCC_OFF_LSTAT, 32'h03);
        settle(2);
        chk(irq_n, 32'h1);
        rchk(`DCC_OFF_LSTAT, 32'h00);
        @(posedge sys_clk);
        latched_events <= 8'h02;
        @(posedge sys_clk);
        latched_events <= 8'h00;
        settle(3);
        chk(irq_n, 32'h1);
        rchk(`DCC_OFF_LSTAT, 32'h02);
    endtask

    // reset for six cycles, then the scenarios in turn
    initial
    begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        latched_events = 8'h00;
        live_sources = 8'h00;
        bclk_cnt = 3'h0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset_map();
        t_clocks();
        t_spdif();
        t_irq();
        print_verdict();
    end
endmodule

bind dcc_clock_ctrl dcc_clock_ctrl_checker #(.NSTAT(NSTAT)) u_dcc_clock_ctrl_checker (.sys_clk, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .latched_events, .live_sources, .sysclk_en,
    .spdif_enable, .sleep_out, .imm_wr, .imm_addr, .imm_wdata, .irq_n);

// ### testbench/dcc_host_model.sv
// register-port master standing in for the host controller
`timescale 1ns/100ps
`include "dcc_consts.vh"
module dcc_host_model (
    // clock
    input  wire logic                   sys_clk,
    // register port
    output logic      [`DCC_ADDR_W-1:0] reg_addr,
    output logic      [31:0]            reg_wdata,
    output logic                        reg_wr,
    output logic                        reg_rd,
    input  wire logic [31:0]            reg_rdata
);
    // idle bus at time zero
    initial
    begin
        reg_addr = 10'h3FF;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one-cycle write; junk in the upper bytes must be ignored
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= {24'hA5A5A5, d};
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~reg_wdata;
    endtask

    // one-cycle read; data taken in the cycle after the strobe
    task automatic rd(input logic [9:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata;
    endtask
endmodule
